// File: mfs_flag_bank.sv
// Module-level flag bank with lane-flag page summaries, reached over an
// Avalon-MM slave with waitrequest.
// Assumes event and condition inputs synchronous to clk, and per-bank,
// per-page "any flag set" levels supplied by the lane flag pages.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module mfs_flag_bank #(
   parameter int NUM_BANKS = 4,
   parameter bit PAGED_MEMORY = 1'b1,
   parameter int CMD_BLOCKS = 2,
   parameter logic [5:0] MON_PRESENT = 6'h3f
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [mfs_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [mfs_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [mfs_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic state_change_evt,
   input wire logic main_fw_fail_evt,
   input wire logic aux_processor_fw_fail_evt,
   input wire logic cmd_block1_done_evt,
   input wire logic cmd_block2_done_evt,
   input wire logic [7:0] supply_temp_cond,
   input wire logic [7:0] aux_ab_cond,
   input wire logic [7:0] aux_c_vendor_cond,
   input wire logic [7:0] vendor_custom_cond,
   input wire logic [15:0] lane_page_flag_any,
   output logic irq
);

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   // Out-of-range counts have no logic below
   if (NUM_BANKS < 1 || NUM_BANKS > mfs_pkg::MAX_BANKS) begin : g_bad_banks
      $error("NUM_BANKS must lie between 1 and 4");
   end
   if (CMD_BLOCKS < 0 || CMD_BLOCKS > 2) begin : g_bad_cmd
      $error("CMD_BLOCKS must lie between 0 and 2");
   end

   // ------------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------------
   // Latched flag update: set wins over a clearing read
   // Clear first, set last: nothing is lost
   function automatic logic [7:0] latch_next(input logic [7:0] cur,
                                             input logic [7:0] clr,
                                             input logic [7:0] set);
      latch_next = (cur & ~clr) | set;
   endfunction : latch_next

   // Threshold nibbles gated by monitor presence
   function automatic logic [7:0] gate_pair(input logic [7:0] cond,
                                            input logic hi_present,
                                            input logic lo_present);
      gate_pair = cond & {{4{hi_present}}, {4{lo_present}}};
   endfunction : gate_pair

   // ------------------------------------------------------------------
   // Latched flag registers
   // ------------------------------------------------------------------
   // One byte per latched host register
   logic [7:0] module_event_flags;
   logic [7:0] supply_temp_threshold_flags;
   logic [7:0] aux1_aux2_threshold_flags;
   logic [7:0] aux3_vendor_threshold_flags;
   logic [7:0] vendor_custom_flags;
   // Interrupt status and enable are local
   logic [mfs_pkg::IRQ_W-1:0] irq_status;
   logic [mfs_pkg::IRQ_W-1:0] irq_enable;

   // ------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------
   // One wait cycle per transfer, never more:
   // taken while waitrequest is high, done
   // at the next edge, when it is low.
   // Writes reach only the irq clear and
   // enable words; others complete idle.
   wire logic [mfs_pkg::IDX_W-1:0] word_idx;
   wire logic bus_req;
   wire logic rd_load;
   wire logic rd_accept;
   wire logic wr_accept;
   wire logic byte0_en;
   wire logic sel_event;
   wire logic sel_supply_temp;
   wire logic sel_aux_ab;
   wire logic sel_aux_c_vendor;
   wire logic sel_vendor_custom;
   wire logic sel_irq_clear;
   wire logic sel_irq_enable;

   // Word index from the byte address; low two bits are ignored
   assign word_idx = avs_address[mfs_pkg::IDX_W+1:2];
   assign bus_req = avs_read | avs_write;
   // Read data are captured on the edge that drops waitrequest
   assign rd_load = avs_read & avs_waitrequest;
   // A transfer completes on the edge where waitrequest is seen low
   assign rd_accept = avs_read & ~avs_waitrequest;
   assign wr_accept = avs_write & ~avs_waitrequest;
   assign byte0_en = avs_byteenable[0];

   // Register selects
   assign sel_event = (word_idx == mfs_pkg::IDX_MODULE_EVENT);
   assign sel_supply_temp = (word_idx == mfs_pkg::IDX_SUPPLY_TEMP);
   assign sel_aux_ab = (word_idx == mfs_pkg::IDX_AUX1_AUX2);
   assign sel_aux_c_vendor = (word_idx == mfs_pkg::IDX_AUX3_VENDOR);
   assign sel_vendor_custom = (word_idx == mfs_pkg::IDX_VENDOR_CUSTOM);
   assign sel_irq_clear = (word_idx == mfs_pkg::IDX_IRQ_CLEAR);
   assign sel_irq_enable = (word_idx == mfs_pkg::IDX_IRQ_ENABLE);

   // ------------------------------------------------------------------
   // Lane page summaries
   // ------------------------------------------------------------------
   // Not latched here: the lane pages keep
   // their own flags, so a summary falls once
   // the host has read every flag behind it.
   wire logic [15:0] bank_present;
   wire logic [15:0] summary_live;
   wire logic [7:0] bank0_lane_flag_summary;
   wire logic [7:0] bank1_lane_flag_summary;
   wire logic [7:0] bank2_lane_flag_summary;
   wire logic [7:0] bank3_lane_flag_summary;

   // Absent banks report no flags
   assign bank_present = {{4{NUM_BANKS > 3}}, {4{NUM_BANKS > 2}},
                          {4{NUM_BANKS > 1}}, 4'hf};
   assign summary_live = lane_page_flag_any & bank_present;
   assign bank0_lane_flag_summary = {4'h0, summary_live[3:0]};
   assign bank1_lane_flag_summary = {4'h0, summary_live[7:4]};
   assign bank2_lane_flag_summary = {4'h0, summary_live[11:8]};
   assign bank3_lane_flag_summary = {4'h0, summary_live[15:12]};
   // summary reads clear nothing; no clear path exists for bytes 4..7

   // ------------------------------------------------------------------
   // Flag set conditions
   // ------------------------------------------------------------------
   // Sources are levels sampled every edge;
   // a held condition re-sets its flag.
   wire logic paged;
   wire logic [7:0] set_event;
   wire logic [7:0] set_supply_temp;
   wire logic [7:0] set_aux_ab;
   wire logic [7:0] set_aux_c_vendor;
   wire logic [7:0] set_vendor_custom;

   // flat memory never latches any module flag
   assign paged = PAGED_MEMORY;

   // optional command block completions in bits 7 and 6
   // auxiliary firmware failure in bit 2, bits 5..3 stay zero
   // main firmware failure in bit 1
   assign set_event = {8{paged}} & {
      cmd_block2_done_evt & (CMD_BLOCKS > 1),
      cmd_block1_done_evt & (CMD_BLOCKS > 0),
      3'h0,
      aux_processor_fw_fail_evt,
      main_fw_fail_evt,
      state_change_evt};

   assign set_supply_temp = {8{paged}} & gate_pair(supply_temp_cond,
      MON_PRESENT[mfs_pkg::MON_SUPPLY], MON_PRESENT[mfs_pkg::MON_TEMP]);

   assign set_aux_ab = {8{paged}} & gate_pair(aux_ab_cond,
      MON_PRESENT[mfs_pkg::MON_AUX_B], MON_PRESENT[mfs_pkg::MON_AUX_A]);

   assign set_aux_c_vendor = {8{paged}} & gate_pair(aux_c_vendor_cond,
      MON_PRESENT[mfs_pkg::MON_VENDOR], MON_PRESENT[mfs_pkg::MON_AUX_C]);

   // vendor custom flags in byte 13
   assign set_vendor_custom = {8{paged}} & vendor_custom_cond;

   // ------------------------------------------------------------------
   // Clear-on-read masks
   // ------------------------------------------------------------------
   // Only the bits actually returned to the host are cleared, so a flag
   // raised after the data were captured is kept for the next read.
   // The byte stays on the read data port up
   // to the accept edge while the request is held.
   wire logic [7:0] reported;
   wire logic [7:0] clr_event;
   wire logic [7:0] clr_supply_temp;
   wire logic [7:0] clr_aux_ab;
   wire logic [7:0] clr_aux_c_vendor;
   wire logic [7:0] clr_vendor_custom;

   assign reported = avs_readdata[7:0];
   // host read clears the reported flags
   assign clr_event = {8{rd_accept & sel_event}} & reported;
   assign clr_supply_temp = {8{rd_accept & sel_supply_temp}} & reported;
   assign clr_aux_ab = {8{rd_accept & sel_aux_ab}} & reported;
   assign clr_aux_c_vendor = {8{rd_accept & sel_aux_c_vendor}} & reported;
   assign clr_vendor_custom = {8{rd_accept & sel_vendor_custom}} & reported;

   // ------------------------------------------------------------------
   // Next flag values
   // ------------------------------------------------------------------
   // Next values feed only the registers below;
   // interrupt edges come from set terms and current flags.
   wire logic [7:0] next_module_event_flags;
   wire logic [7:0] next_supply_temp_threshold_flags;
   wire logic [7:0] next_aux1_aux2_threshold_flags;
   wire logic [7:0] next_aux3_vendor_threshold_flags;
   wire logic [7:0] next_vendor_custom_flags;

   // set wins over the clearing read
   assign next_module_event_flags = latch_next(module_event_flags, clr_event, set_event);
   assign next_supply_temp_threshold_flags =
      latch_next(supply_temp_threshold_flags, clr_supply_temp, set_supply_temp);
   assign next_aux1_aux2_threshold_flags =
      latch_next(aux1_aux2_threshold_flags, clr_aux_ab, set_aux_ab);
   assign next_aux3_vendor_threshold_flags =
      latch_next(aux3_vendor_threshold_flags, clr_aux_c_vendor, set_aux_c_vendor);
   assign next_vendor_custom_flags =
      latch_next(vendor_custom_flags, clr_vendor_custom, set_vendor_custom);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         module_event_flags <= mfs_pkg::FLAG_RESET;
         supply_temp_threshold_flags <= mfs_pkg::FLAG_RESET;
         aux1_aux2_threshold_flags <= mfs_pkg::FLAG_RESET;
         aux3_vendor_threshold_flags <= mfs_pkg::FLAG_RESET;
         vendor_custom_flags <= mfs_pkg::FLAG_RESET;
      end else begin
         module_event_flags <= next_module_event_flags;
         supply_temp_threshold_flags <= next_supply_temp_threshold_flags;
         aux1_aux2_threshold_flags <= next_aux1_aux2_threshold_flags;
         aux3_vendor_threshold_flags <= next_aux3_vendor_threshold_flags;
         vendor_custom_flags <= next_vendor_custom_flags;
      end
   end

   // ------------------------------------------------------------------
   // Interrupt status, enable and clear
   // ------------------------------------------------------------------
   // Status records rising flags only, so a
   // held condition does not retrigger it.
   // Software clears status after reading
   // the flag bytes that it points to.
   wire logic [mfs_pkg::IRQ_W-1:0] irq_set;
   wire logic [mfs_pkg::IRQ_W-1:0] irq_clr;
   wire logic [mfs_pkg::IRQ_W-1:0] next_irq_status;
   wire logic [mfs_pkg::IRQ_W-1:0] next_irq_enable;
   wire logic next_irq;

   // A group event is any flag of the group rising from clear to set
   assign irq_set[mfs_pkg::IRQ_MODULE_EVENT] = |(set_event & ~module_event_flags);
   assign irq_set[mfs_pkg::IRQ_SUPPLY_TEMP] =
      |(set_supply_temp & ~supply_temp_threshold_flags);
   assign irq_set[mfs_pkg::IRQ_AUX1_AUX2] = |(set_aux_ab & ~aux1_aux2_threshold_flags);
   assign irq_set[mfs_pkg::IRQ_AUX3_VENDOR] =
      |(set_aux_c_vendor & ~aux3_vendor_threshold_flags);
   assign irq_set[mfs_pkg::IRQ_VENDOR_CUSTOM] =
      |(set_vendor_custom & ~vendor_custom_flags);

   // Write-one-to-clear through the clear register; set wins
   assign irq_clr = {mfs_pkg::IRQ_W{wr_accept & sel_irq_clear & byte0_en}} &
                    avs_writedata[mfs_pkg::IRQ_W-1:0];
   assign next_irq_status = (irq_status & ~irq_clr) | irq_set;
   assign next_irq_enable = (wr_accept & sel_irq_enable & byte0_en) ?
                            avs_writedata[mfs_pkg::IRQ_W-1:0] : irq_enable;
   assign next_irq = |(next_irq_status & next_irq_enable);

   // Sticky status, enable and registered interrupt level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_status <= mfs_pkg::IRQ_RESET;
         irq_enable <= mfs_pkg::IRQ_RESET;
         irq <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq_enable <= next_irq_enable;
         irq <= next_irq;
      end
   end

   // ------------------------------------------------------------------
   // Read data selection
   // ------------------------------------------------------------------
   // Words are distinct, so the chain order
   // is free; byte 12 and the clear word
   // read as zero.
   logic [7:0] read_byte;

   // Reserved, write-only and unmapped words read as zero
   always_comb begin
      read_byte = 8'h00;
      if (word_idx == mfs_pkg::IDX_BANK0_SUMMARY) begin
         read_byte = bank0_lane_flag_summary;
      end else if (word_idx == mfs_pkg::IDX_BANK1_SUMMARY) begin
         read_byte = bank1_lane_flag_summary;
      end else if (word_idx == mfs_pkg::IDX_BANK2_SUMMARY) begin
         read_byte = bank2_lane_flag_summary;
      end else if (word_idx == mfs_pkg::IDX_BANK3_SUMMARY) begin
         read_byte = bank3_lane_flag_summary;
      end else if (sel_event) begin
         read_byte = module_event_flags;
      end else if (sel_supply_temp) begin
         read_byte = supply_temp_threshold_flags;
      end else if (sel_aux_ab) begin
         read_byte = aux1_aux2_threshold_flags;
      end else if (sel_aux_c_vendor) begin
         read_byte = aux3_vendor_threshold_flags;
      end else if (sel_vendor_custom) begin
         read_byte = vendor_custom_flags;
      end else if (word_idx == mfs_pkg::IDX_IRQ_STATUS) begin
         read_byte = {3'h0, irq_status};
      end else if (sel_irq_enable) begin
         read_byte = {3'h0, irq_enable};
      end
   end

   // ------------------------------------------------------------------
   // Bus handshake
   // ------------------------------------------------------------------
   // Waitrequest rests high between requests;
   // a new request may follow a completion.
   // Read data load on the taking edge only.
   wire logic next_waitrequest;

   // Each request is held one cycle, answered the next, then released
   assign next_waitrequest = ~(bus_req & avs_waitrequest);

   // Waitrequest and captured read data
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= mfs_pkg::WAIT_RESET;
         avs_readdata <= mfs_pkg::RDATA_RESET;
      end else begin
         avs_waitrequest <= next_waitrequest;
         if (rd_load) begin
            avs_readdata <= {24'h00_0000, read_byte};
         end
      end
   end

endmodule : mfs_flag_bank

`default_nettype wire

// File: mfs_flag_bank_assertions.sv
// Concurrent checks on the flag bank: bus answer, summaries, latches, irq.
// Assumes it is bound to mfs_flag_bank and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module mfs_flag_bank_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic state_change_evt,
   input wire logic main_fw_fail_evt,
   input wire logic aux_processor_fw_fail_evt,
   input wire logic cmd_block1_done_evt,
   input wire logic cmd_block2_done_evt,
   input wire logic [7:0] supply_temp_cond,
   input wire logic [7:0] aux_ab_cond,
   input wire logic [7:0] aux_c_vendor_cond,
   input wire logic [7:0] vendor_custom_cond,
   input wire logic [15:0] lane_page_flag_any,
   input wire logic irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Anything that may legally raise the interrupt
   wire logic any_cause = state_change_evt | main_fw_fail_evt | aux_processor_fw_fail_evt
      | cmd_block1_done_evt | cmd_block2_done_evt | (|supply_temp_cond) | (|aux_ab_cond)
      | (|aux_c_vendor_cond) | (|vendor_custom_cond) | avs_write;
   sequence s_take;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_evt_rd;
      state_change_evt ##1 (avs_read && avs_waitrequest && avs_address == 8'h20);
   endsequence
   sequence s_quiet_reread;
      (supply_temp_cond == 8'h00 && avs_read && avs_waitrequest && avs_address == 8'h24)
      ##1 (supply_temp_cond == 8'h00 && avs_read && !avs_waitrequest)
      ##1 supply_temp_cond == 8'h00 ##1 (avs_read && avs_waitrequest && avs_address == 8'h24);
   endsequence
   a_wait_one_low: assert property (s_take |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("waitrequest not low for exactly one cycle");
   a_summary_live: assert property (avs_read && avs_waitrequest
      && avs_address[7:4] == 4'h1 |=> avs_readdata
      == 32'(($past(lane_page_flag_any) >> {avs_address[3:2], 2'b00}) & 16'hf))
      else $error("summary byte differs from page flags");
   a_state_latch: assert property (s_evt_rd |=> avs_readdata[0])
      else $error("state change not latched");
   a_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_event_rsvd: assert property (avs_read && !avs_waitrequest && avs_address == 8'h20
      |-> avs_readdata[5:3] == 3'h0)
      else $error("reserved event bits set");
   a_clear_on_read: assert property (s_quiet_reread |=> avs_readdata == 32'h0)
      else $error("flag not cleared by read");
   a_irq_cause: assert property ($rose(irq) |-> $past(any_cause))
      else $error("irq rose without cause");
   a_irq_mask: assert property ((avs_write && !avs_waitrequest && avs_address == 8'h48
      && avs_byteenable[0] && avs_writedata[4:0] == 5'h00) |=> !irq)
      else $error("irq high with all enables off");
endmodule : mfs_flag_bank_assertions
bind mfs_flag_bank mfs_flag_bank_assertions chk (.clk, .rst, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
   .state_change_evt, .main_fw_fail_evt, .aux_processor_fw_fail_evt, .cmd_block1_done_evt,
   .cmd_block2_done_evt, .supply_temp_cond, .aux_ab_cond, .aux_c_vendor_cond,
   .vendor_custom_cond, .lane_page_flag_any, .irq);
`default_nettype wire

// File: mfs_host_model.sv
// Host side of the management bus: an Avalon-MM master with waitrequest.
// Assumes a slave that answers in its own time; waitrequest is looked at
// on rising edges only.
`timescale 1ns/1ps
`default_nettype none
module mfs_host_model (
   input wire logic clk,
   output logic [7:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic avs_waitrequest
);
   // Idle bus from time zero
   initial begin
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
   end
   // flags cleared only by reading them
   // Hold the request until waitrequest is low at a rising edge, then release
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic [3:0] be);
      @(posedge clk);
      avs_address <= a;
      avs_read <= !w;
      avs_write <= w;
      avs_writedata <= d;
      avs_byteenable <= be;
      do @(posedge clk); while (avs_waitrequest);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : xfer
endmodule : mfs_host_model
`default_nettype wire

// File: mfs_pkg.sv
// Constants for the module flag summary bank: register indices, field
// positions, reset values and interrupt layout.
// Assumes a 32-bit register bus in which each register takes one aligned word.
`default_nettype none

package mfs_pkg;

   // ------------------------------------------------------------------
   // Bus geometry
   // ------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int IDX_W = 6;

   // ------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_BANK0_SUMMARY = 6'h04;
   localparam logic [IDX_W-1:0] IDX_BANK1_SUMMARY = 6'h05;
   localparam logic [IDX_W-1:0] IDX_BANK2_SUMMARY = 6'h06;
   localparam logic [IDX_W-1:0] IDX_BANK3_SUMMARY = 6'h07;
   localparam logic [IDX_W-1:0] IDX_MODULE_EVENT = 6'h08;
   localparam logic [IDX_W-1:0] IDX_SUPPLY_TEMP = 6'h09;
   localparam logic [IDX_W-1:0] IDX_AUX1_AUX2 = 6'h0a;
   localparam logic [IDX_W-1:0] IDX_AUX3_VENDOR = 6'h0b;
   localparam logic [IDX_W-1:0] IDX_RESERVED = 6'h0c;
   localparam logic [IDX_W-1:0] IDX_VENDOR_CUSTOM = 6'h0d;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h10;
   localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 6'h11;
   localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 6'h12;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   // Summary byte: one bit per lane-flag page
   localparam int SUM_PAGE_A = 0;
   localparam int SUM_PAGE_B = 1;
   localparam int SUM_PAGE_C = 2;
   localparam int SUM_PAGE_D = 3;
   localparam int PAGES_PER_BANK = 4;
   localparam int MAX_BANKS = 4;
   // Module event byte
   localparam int EV_STATE_CHANGE = 0;
   localparam int EV_MAIN_FW_FAIL = 1;
   localparam int EV_AUX_FW_FAIL = 2;
   localparam int EV_CMD_BLOCK1 = 6;
   localparam int EV_CMD_BLOCK2 = 7;
   // Threshold nibble, same order for every monitor
   localparam int THR_HIGH_ALARM = 0;
   localparam int THR_LOW_ALARM = 1;
   localparam int THR_HIGH_WARN = 2;
   localparam int THR_LOW_WARN = 3;
   localparam int THR_UPPER = 4;
   // Monitor presence bits
   localparam int MON_TEMP = 0;
   localparam int MON_SUPPLY = 1;
   localparam int MON_AUX_A = 2;
   localparam int MON_AUX_B = 3;
   localparam int MON_AUX_C = 4;
   localparam int MON_VENDOR = 5;
   // Interrupt status, enable and clear layout
   localparam int IRQ_W = 5;
   localparam int IRQ_MODULE_EVENT = 0;
   localparam int IRQ_SUPPLY_TEMP = 1;
   localparam int IRQ_AUX1_AUX2 = 2;
   localparam int IRQ_AUX3_VENDOR = 3;
   localparam int IRQ_VENDOR_CUSTOM = 4;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] FLAG_RESET = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;
   localparam logic WAIT_RESET = 1'b1;
   localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

endpackage : mfs_pkg

`default_nettype wire

// File: testbench.sv
// Self-checking bench for the flag bank: reads are noted in a queue and
// compared by a monitor when the read completes.
// Assumes the host model as bus master and the checker bound to the design.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin failures++; \
   $display("CHECK FAILED t=%0t %s", $time, msg); end end
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [36:0] stim = '0;
   logic [15:0] lane = 16'h0;
   logic [31:0] seed = 32'he6fe;
   logic [31:0] exp_q[$];
   int failures = 0;
   int n_checks = 0;
   logic [7:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic irq;
   // Clock at 25 MHz
   always #20 clk = ~clk;
   mfs_host_model host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_waitrequest(avs_waitrequest));
   mfs_flag_bank uut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .state_change_evt(stim[32]), .main_fw_fail_evt(stim[33]),
      .aux_processor_fw_fail_evt(stim[34]), .cmd_block1_done_evt(stim[35]),
      .cmd_block2_done_evt(stim[36]), .supply_temp_cond(stim[31:24]),
      .aux_ab_cond(stim[23:16]), .aux_c_vendor_cond(stim[15:8]),
      .vendor_custom_cond(stim[7:0]), .lane_page_flag_any(lane), .irq(irq));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      host.xfer(a, 1'b0, 32'h0, 4'hf);
   endtask : rd
   task automatic pulse(input logic [36:0] v);
      @(posedge clk);
      stim <= v;
      @(posedge clk);
      stim <= '0;
   endtask : pulse
   task automatic print_verdict();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   // Compare each completed read with the oldest noted value
   always @(posedge clk) begin
      if (avs_read && !avs_waitrequest) `CHK(avs_readdata, exp_q.pop_front(), "read data")
   end
   // Watchdog against a hung handshake
   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      print_verdict();
   end
   // Main sequence
   initial begin
      logic [7:0] v;
      logic [7:0] ta;
      logic [15:0] ln;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int i = 4; i < 16; i++) rd(8'(i * 4), 32'h0);
      $display("test reset values done");
      for (int i = 0; i < 5; i++) begin
         pulse(37'(1) << (32 + i));
         rd(8'h20, 32'(1) << ((i < 3) ? i : i + 3));
         rd(8'h20, 32'h0);
      end
      $display("test event flags done");
      for (int k = 0; k < 12; k++) begin
         seed = lfsr(seed);
         v = (k < 4) ? 8'hff : seed[7:0];
         ta = (k % 4 == 3) ? 8'h34 : 8'h24 + 8'(4 * (k % 4));
         pulse(37'(v) << (8 * (3 - k % 4)));
         rd(ta, {24'h0, v});
         rd(ta, 32'h0);
      end
      pulse({5'h1f, 32'hffff_ffff});
      rd(8'h30, 32'h0);
      for (int i = 8; i < 14; i++) if (i != 12) rd(8'(i * 4), (i == 8) ? 32'hc7 : 32'hff);
      $display("test threshold flags done");
      for (int r = 0; r < 3; r++) begin
         seed = lfsr(seed);
         ln = (r == 0) ? 16'hffff : seed[15:0];
         @(posedge clk) lane <= ln;
         for (int b = 0; b < 4; b++) begin
            rd(8'h10 + 8'(4 * b), 32'((ln >> (4 * b)) & 16'hf));
            rd(8'h10 + 8'(4 * b), 32'((ln >> (4 * b)) & 16'hf));
         end
      end
      // host has read the page flags
      @(posedge clk) lane <= 16'h0;
      rd(8'h10, 32'h0);
      $display("test summaries done");
      @(posedge clk) stim <= 37'h01_0000_0000;
      rd(8'h20, 32'h1);
      @(posedge clk) stim <= '0;
      rd(8'h20, 32'h1);
      rd(8'h20, 32'h0);
      $display("test set during clear done");
      rd(8'h40, 32'h1f);
      host.xfer(8'h44, 1'b1, 32'h1f, 4'h1);
      host.xfer(8'h48, 1'b1, 32'h1, 4'h1);
      @(negedge clk) `CHK(irq, 1'b0, "irq idle")
      pulse(37'h01_0000_0000);
      @(negedge clk) `CHK(irq, 1'b1, "irq raised")
      rd(8'h40, 32'h1);
      host.xfer(8'h48, 1'b1, 32'h0, 4'h1);
      @(negedge clk) `CHK(irq, 1'b0, "irq masked")
      host.xfer(8'h48, 1'b1, 32'h1, 4'h0);
      @(negedge clk) `CHK(irq, 1'b0, "byte lane off")
      host.xfer(8'h48, 1'b1, 32'h1, 4'h1);
      @(negedge clk) `CHK(irq, 1'b1, "irq unmasked")
      rd(8'h20, 32'h1);
      host.xfer(8'h44, 1'b1, 32'h1, 4'h1);
      @(negedge clk) `CHK(irq, 1'b0, "irq cleared")
      rd(8'h40, 32'h0);
      host.xfer(8'h20, 1'b1, 32'hff, 4'hf);
      rd(8'h20, 32'h0);
      $display("test interrupt done");
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
